// ---- hdl/flag_ram_host.sv ----
// host controller for one port of a dual-port memory with hardware flag latches
`timescale 1ns/10ps
`default_nettype none
// Function
// R01: write spans select low and strobe low
// R02: strobe high whenever address lines change
// R03: device floats data while writing
// R04: no simultaneous same-location access across ports
// R05: other port's write flows through after delay
// R06: memory read drives enable and select low
// R07: flag select low keeps memory select high
// R08: three low address bits pick the flag
// R09: enable and strobe work alike for flags
// R10: flag write uses data bit zero only
// R11: writing zero to free flag grants it
// R12: owner writing one frees the flag
// R13: pending request gains flag on release
// R14: flag read drives value on all lines
// R15: flag read value held in register
// R16: simultaneous requests grant exactly one port
// R17: deselect for update gap before read-back
// R18: claim by write zero, read back, poll
// R19: write one to all flags at start
// R20: flag modelled as requests plus owner
module flag_ram_host (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // command port
    input wire logic cmd_valid_in,
    input wire flag_ram_pkg::cmd_t cmd_in,
    output logic cmd_ready_out,
    // response port
    output logic resp_valid_out,
    output flag_ram_pkg::resp_t resp_out,
    output logic init_busy_out,
    // device pins
    output flag_ram_pkg::port_pins_t pins_out,
    input wire logic [flag_ram_pkg::DATA_W-1:0] port_data_in,
    output logic [flag_ram_pkg::DATA_W-1:0] port_data_out,
    output logic port_data_oe_out
);
    import flag_ram_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_WRITE = 3'b011,
        ST_HOLD = 3'b010,
        ST_GAP = 3'b110,
        ST_READ = 3'b111,
        ST_RESP = 3'b101
    } state_t;

    state_t state;
    state_t next_state;
    op_t op;
    op_t take_op;
    logic [ADDR_W-1:0] take_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [FLAG_IDX_W-1:0] init_idx;
    logic [CNT_W-1:0] polls;
    logic [CNT_W-1:0] timer_count;
    logic init_pending;
    logic next_init;
    logic in_init;
    logic phase_read;
    logic go_read;
    logic again;
    logic take;
    logic timer_done;
    logic in_gap;

    phase_timer timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(next_state != state),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    // one access at a time; software keeps both ports off one shared word [R04]
    assign take = (state == ST_IDLE) && (init_pending || (cmd_valid_in && cmd_ready_out));
    assign take_op = init_pending ? OP_FLAG_RELEASE : cmd_in.op;
    assign take_addr = init_pending ? {FLAG_ADDR_PAD, init_idx} : cmd_in.addr;
    // keep polling while the flag reads back as held by the other port
    assign again = (op == OP_FLAG_CLAIM) && port_data_in[0] && (polls != CNT_ZERO); // [R18]
    assign next_init = init_pending &&
        !((state == ST_HOLD) && timer_done && in_init && (init_idx == FLAG_LAST));
    assign in_gap = (state == ST_GAP);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_state = phase_read ? ST_READ : ST_WRITE;
            end
            ST_WRITE: begin
                if (timer_done) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (timer_done) begin
                    if (op == OP_FLAG_CLAIM) begin
                        next_state = ST_GAP; // [R17]
                    end else if (in_init) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_RESP;
                    end
                end
            end
            ST_READ: begin
                if (timer_done) begin
                    next_state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (timer_done) begin
                    next_state = go_read ? ST_SETUP : ST_RESP;
                end
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        unique case (next_state)
            ST_WRITE: timer_count = WRITE_CYC;
            ST_HOLD: timer_count = HOLD_CYC;
            ST_READ: timer_count = READ_CYC; // [R06]
            ST_GAP: timer_count = GAP_CYC; // [R17]
            default: timer_count = CNT_ZERO;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // power-up sweep frees every flag from this side
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            init_pending <= 1'b1;
            init_idx <= FLAG_FIRST;
        end else if ((state == ST_HOLD) && timer_done && in_init) begin
            init_pending <= next_init; // [R19]
            init_idx <= init_idx + 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            op <= OP_MEM_RD;
            wdata <= '0;
            in_init <= 1'b0;
            phase_read <= 1'b0;
            go_read <= 1'b0;
            polls <= CNT_ZERO;
            rdata <= '0;
        end else if (take) begin
            op <= take_op;
            wdata <= cmd_in.data;
            in_init <= init_pending;
            phase_read <= is_read_op(take_op);
            go_read <= 1'b0;
            polls <= POLL_MAX;
        end else if ((state == ST_HOLD) && timer_done && (op == OP_FLAG_CLAIM)) begin
            phase_read <= 1'b1; // [R18]
            go_read <= 1'b1;
        end else if ((state == ST_READ) && timer_done) begin
            rdata <= port_data_in; // [R14]
            go_read <= again;
            if (again) begin
                polls <= polls - CNT_ONE;
            end
        end
    end

    // pin sequencing; address moves only while the strobe is high
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pins_out <= '{ce_n: 1'b1, flag_latch_select_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1,
                addr: '0};
            port_data_out <= '0;
            port_data_oe_out <= 1'b0;
        end else begin
            if (take) begin
                pins_out.addr <= is_flag_op(take_op) ?
                    {FLAG_ADDR_PAD, take_addr[FLAG_IDX_W-1:0]} : take_addr; // [R02] [R08]
            end
            if (state == ST_SETUP) begin
                pins_out.ce_n <= is_flag_op(op); // [R07]
                pins_out.flag_latch_select_n <= !is_flag_op(op); // [R09]
                if (phase_read) begin
                    pins_out.oe_n <= 1'b0; // [R06]
                end else begin
                    // enable stays high so the device floats its drivers
                    pins_out.rw_n <= 1'b0; // [R01] [R03]
                    port_data_oe_out <= 1'b1;
                    if (is_flag_op(op)) begin
                        port_data_out <= {FLAG_DATA_PAD,
                            (op == OP_FLAG_RELEASE) ? FLAG_FREE : FLAG_TAKE}; // [R10]
                    end else begin
                        port_data_out <= wdata;
                    end
                end
            end
            if ((state == ST_WRITE) && timer_done) begin
                pins_out.rw_n <= 1'b1; // [R01]
            end
            if (((state == ST_HOLD) || (state == ST_READ)) && timer_done) begin
                pins_out.ce_n <= 1'b1;
                pins_out.flag_latch_select_n <= 1'b1; // [R17]
                pins_out.oe_n <= 1'b1;
                port_data_oe_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            resp_valid_out <= 1'b0;
            resp_out <= '0;
            cmd_ready_out <= 1'b0;
            init_busy_out <= 1'b1;
        end else begin
            resp_valid_out <= (next_state == ST_RESP);
            if (next_state == ST_RESP) begin
                resp_out.data <= phase_read ? rdata : '0;
                resp_out.granted <= (op == OP_FLAG_CLAIM) && !rdata[0]; // [R18]
            end
            cmd_ready_out <= (next_state == ST_IDLE) && !next_init;
            init_busy_out <= next_init;
        end
    end

    strobe_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R02]
        $changed(pins_out.addr) |-> pins_out.rw_n && $past(pins_out.rw_n))
        else $error("address moved while write strobe low");
    select_excl_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R07]
        !pins_out.flag_latch_select_n |-> pins_out.ce_n)
        else $error("memory select low during flag access");
    flag_index_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R08]
        !pins_out.flag_latch_select_n |-> (pins_out.addr[ADDR_W-1:FLAG_IDX_W] == FLAG_ADDR_PAD))
        else $error("flag access with upper address bits set");
    flag_data_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R10]
        (!pins_out.flag_latch_select_n && !pins_out.rw_n) |-> (port_data_out[DATA_W-1:1] == '0))
        else $error("flag write drives bits above bit zero");
    write_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R03]
        port_data_oe_out |-> pins_out.oe_n)
        else $error("host drives data while output enable low");
    read_enable_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R06]
        $rose(state == ST_READ) |-> (!pins_out.oe_n && !(pins_out.ce_n &&
            pins_out.flag_latch_select_n))[*8])
        else $error("read phase without enable and select low");
    update_gap_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R17]
        $rose(in_gap) |-> (in_gap && pins_out.flag_latch_select_n && pins_out.oe_n)[*4])
        else $error("flag update gap shorter than required");
    write_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R01]
        $fell(pins_out.rw_n) |-> (!pins_out.rw_n && port_data_oe_out)[*8])
        else $error("write pulse ended early");
    claim_grant_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R18]
        (resp_valid_out && resp_out.granted) |-> ($past(op) == OP_FLAG_CLAIM) && !rdata[0])
        else $error("grant reported without a zero read-back");
    init_free_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R19]
        (in_init && !pins_out.rw_n) |-> (!pins_out.flag_latch_select_n &&
            port_data_out[0] == FLAG_FREE))
        else $error("start-up sweep did not write one to a flag");
endmodule
`default_nettype wire

// ---- hdl/flag_ram_pkg.sv ----
// shared types and timing constants for the dual-port memory host controller
package flag_ram_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int FLAG_IDX_W = 3;
    localparam int CNT_W = 8;

    localparam logic [FLAG_IDX_W-1:0] FLAG_FIRST = 3'h0;
    localparam logic [FLAG_IDX_W-1:0] FLAG_LAST = 3'h7;
    localparam logic FLAG_FREE = 1'b1;
    localparam logic FLAG_TAKE = 1'b0;
    localparam logic [ADDR_W-FLAG_IDX_W-1:0] FLAG_ADDR_PAD = 9'h000;
    localparam logic [DATA_W-2:0] FLAG_DATA_PAD = 7'h00;
    localparam logic [CNT_W-1:0] POLL_MAX = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // clock period and device times in ns (slowest speed grade)
    localparam int CLK_NS = 4;
    localparam int READ_ACCESS_NS = 55;
    localparam int WRITE_PULSE_NS = 50;
    localparam int ADDR_HOLD_NS = 2;
    localparam int OUT_FLOAT_NS = 25;
    localparam int FLAG_UPDATE_GAP_NS = 15;
    localparam int DESELECT_NS =
        (FLAG_UPDATE_GAP_NS > OUT_FLOAT_NS) ? FLAG_UPDATE_GAP_NS : OUT_FLOAT_NS;

    // least times round up, never below one cycle
    function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] READ_CYC = ns_to_cyc(READ_ACCESS_NS);
    localparam logic [CNT_W-1:0] WRITE_CYC = ns_to_cyc(WRITE_PULSE_NS);
    localparam logic [CNT_W-1:0] HOLD_CYC = ns_to_cyc(ADDR_HOLD_NS);
    localparam logic [CNT_W-1:0] GAP_CYC = ns_to_cyc(DESELECT_NS);

    typedef enum logic [2:0] {
        OP_MEM_RD = 3'h0,
        OP_MEM_WR = 3'h1,
        OP_FLAG_RD = 3'h2,
        OP_FLAG_CLAIM = 3'h3,
        OP_FLAG_RELEASE = 3'h4
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic granted;
    } resp_t;

    typedef struct packed {
        logic ce_n;
        logic flag_latch_select_n;
        logic oe_n;
        logic rw_n;
        logic [ADDR_W-1:0] addr;
    } port_pins_t;

    function automatic logic is_flag_op(input op_t op);
        return (op == OP_FLAG_RD) || (op == OP_FLAG_CLAIM) || (op == OP_FLAG_RELEASE);
    endfunction

    function automatic logic is_read_op(input op_t op);
        return (op == OP_MEM_RD) || (op == OP_FLAG_RD);
    endfunction

endpackage

// ---- hdl/phase_timer.sv ----
// down-counter that marks the last cycle of a timed bus phase
`timescale 1ns/10ps
`default_nettype none
module phase_timer (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // load
    input wire logic start_in,
    input wire logic [flag_ram_pkg::CNT_W-1:0] count_in,
    // status
    output logic done_out
);
    import flag_ram_pkg::*;

    logic [CNT_W-1:0] cnt;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt <= CNT_ZERO;
        end else if (start_in) begin
            cnt <= count_in;
        end else if (cnt != CNT_ZERO) begin
            cnt <= cnt - CNT_ONE;
        end
    end

    assign done_out = (cnt == CNT_ONE);
endmodule
`default_nettype wire

// ---- verification/flag_ram_device.sv ----
// behavioural dual-port memory with eight flag latches, two host ports
`timescale 1ns/10ps
`default_nettype none
module flag_ram_device
    import flag_ram_pkg::*;
(
    // host ports, index 0 and 1
    input wire port_pins_t pins_in [2],
    input wire logic [DATA_W-1:0] data_in [2],
    output logic [DATA_W-1:0] data_out [2]
);
    logic [DATA_W-1:0] mem [0:4095];
    logic [1:0] req [8];
    logic [7:0] busy;
    logic [7:0] own;
    // arbitrary power-up state: every flag held by port 0
    initial begin
        busy = 8'hff;
        own = 8'h00;
        for (int i = 0; i < 8; i++) req[i] = 2'b01;
    end
    task automatic write_flag(input int s, input logic [2:0] i, input logic b);
        if (!b) begin
            req[i][s] = 1'b1;
            // events are serialised, so only one side can win a free flag
            if (!busy[i]) begin
                busy[i] = 1'b1;
                own[i] = s[0];
            end
        end else begin
            req[i][s] = 1'b0;
            if (busy[i] && own[i] == s[0]) begin
                own[i] = ~own[i];
                busy[i] = req[i][1-s];
            end
        end
    endtask
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic sel, wr, rd;
        logic [DATA_W-1:0] now, held;
        logic [DATA_W-1:0] last = 8'h00;
        assign sel = ~pins_in[p].ce_n | ~pins_in[p].flag_latch_select_n;
        assign wr = sel & ~pins_in[p].rw_n;
        assign rd = sel & pins_in[p].rw_n & ~pins_in[p].oe_n;
        // flag value is registered as the read opens
        always @(posedge rd) begin
            held = (busy[pins_in[p].addr[2:0]] && own[pins_in[p].addr[2:0]] == (p == 1)) ?
                8'h00 : 8'hff;
        end
        assign now = pins_in[p].ce_n ? held : mem[pins_in[p].addr];
        always @* if (rd) last = now;
        // released lines show the inverse of the last value
        assign data_out[p] = rd ? now : ~last;
        always @(negedge wr) begin
            if (!pins_in[p].ce_n) mem[pins_in[p].addr] = data_in[p];
            else write_flag(p, pins_in[p].addr[2:0], data_in[p][0]);
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the flag memory host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check_val(g, e)
module tb_top;
    import flag_ram_pkg::*;
    typedef struct packed {op_t op; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic g;} row_t;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    cmd_t cmd_in = '0;
    logic cmd_ready_out, resp_valid_out, init_busy_out, port_data_oe_out;
    resp_t resp_out;
    resp_t r;
    port_pins_t pins_out;
    port_pins_t b_pins = '1;
    port_pins_t pins [2];
    logic [7:0] dev_in [2];
    logic [7:0] dev_out [2];
    logic [7:0] port_data_out, dut_rd, q;
    logic [7:0] b_dat = 8'h00;
    logic [11:0] prev_addr = 12'h000;
    int n_errors = 0;
    int total_checks = 0;
    row_t rows [10] = '{
        '{OP_MEM_WR, 12'h0a5, 8'h3c, 8'h00, 1'b0}, '{OP_MEM_RD, 12'h0a5, 8'h00, 8'h3c, 1'b0},
        '{OP_MEM_WR, 12'hfff, 8'hc3, 8'h00, 1'b0}, '{OP_MEM_RD, 12'hfff, 8'h00, 8'hc3, 1'b0},
        '{OP_MEM_RD, 12'h0a5, 8'h00, 8'h3c, 1'b0}, '{OP_FLAG_RD, 12'h002, 8'h00, 8'hff, 1'b0},
        '{OP_FLAG_CLAIM, 12'hff9, 8'h00, 8'h00, 1'b1}, '{OP_FLAG_RD, 12'h001, 8'h00, 8'h00, 1'b0},
        '{OP_FLAG_RELEASE, 12'h001, 8'h00, 8'h00, 1'b0},
        '{OP_FLAG_RD, 12'h001, 8'h00, 8'hff, 1'b0}};
    assign pins = '{pins_out, b_pins};
    assign dev_in = '{port_data_out, b_dat};
    assign dut_rd = port_data_oe_out ? port_data_out : dev_out[0];
    initial forever #2 clk_in = ~clk_in;
    flag_ram_host DUT (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .resp_valid_out(resp_valid_out),
        .resp_out(resp_out), .init_busy_out(init_busy_out), .pins_out(pins_out),
        .port_data_in(dut_rd), .port_data_out(port_data_out), .port_data_oe_out(port_data_oe_out));
    flag_ram_device dev (.pins_in(pins), .data_in(dev_in), .data_out(dev_out));
    task check_val(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task run_cmd(input op_t op, input logic [11:0] a, input logic [7:0] d);
        int k;
        cmd_in = '{op, a, d};
        cmd_valid_in = 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (cmd_ready_out !== 1'b1 && k < 400);
        #1 cmd_valid_in = 1'b0;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (resp_valid_out !== 1'b1 && k < 8000);
        r = resp_out;
        if (k >= 8000) n_errors++;
        #1;
    endtask
    // far-side host: address settles with strobe high, strobe released before select
    task b_acc(input logic flag, input logic wr, input logic [11:0] a, input logic [7:0] d);
        b_pins.addr = a;
        b_dat = d;
        repeat (2) @(posedge clk_in);
        #1 b_pins.ce_n = flag;
        b_pins.flag_latch_select_n = ~flag;
        b_pins.oe_n = wr;
        b_pins.rw_n = ~wr;
        repeat (14) @(posedge clk_in);
        q = dev_out[1];
        #1 b_pins.rw_n = 1'b1;
        @(posedge clk_in);
        #1 b_pins.ce_n = 1'b1;
        b_pins.flag_latch_select_n = 1'b1;
        b_pins.oe_n = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
    endtask
    always @(posedge clk_in) begin
        if (nrst_in) begin
            if (pins_out.flag_latch_select_n === 1'b0 && pins_out.ce_n !== 1'b1)
                `CHK(8'h01, 8'h00);
            if (pins_out.addr !== prev_addr && pins_out.rw_n !== 1'b1) `CHK(8'h02, 8'h00);
            if (port_data_oe_out === 1'b1 && pins_out.oe_n !== 1'b1) `CHK(8'h03, 8'h00);
        end
        prev_addr <= pins_out.addr;
    end
    initial begin
        #300000;
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        for (int i = 0; i < 8; i++) b_acc(1'b1, 1'b1, 12'(i), 8'h01);
        for (int i = 0; i < 8; i++) begin
            b_acc(1'b1, 1'b0, 12'(i), 8'h00);
            `CHK(q, 8'hff);
        end
        $display("test start-up done");
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].a, rows[i].d);
            `CHK(r.data, rows[i].x);
            `CHK({7'h00, r.granted}, {7'h00, rows[i].g});
        end
        $display("test table done");
        // the two hosts take turns on shared words
        b_acc(1'b0, 1'b1, 12'h123, 8'h5a);
        run_cmd(OP_MEM_RD, 12'h123, 8'h00);
        `CHK(r.data, 8'h5a);
        run_cmd(OP_MEM_WR, 12'h456, 8'ha5);
        b_acc(1'b0, 1'b0, 12'h456, 8'h00);
        `CHK(q, 8'ha5);
        $display("test cross-port memory done");
        run_cmd(OP_FLAG_CLAIM, 12'h003, 8'h00);
        `CHK({7'h00, r.granted}, 8'h01);
        b_acc(1'b1, 1'b0, 12'h003, 8'h00);
        `CHK(q, 8'hff);
        b_acc(1'b1, 1'b1, 12'h003, 8'h01);
        run_cmd(OP_FLAG_RD, 12'h003, 8'h00);
        `CHK(r.data, 8'h00);
        b_acc(1'b1, 1'b1, 12'hff3, 8'hfe);
        run_cmd(OP_FLAG_RELEASE, 12'h003, 8'h00);
        b_acc(1'b1, 1'b0, 12'h003, 8'h00);
        `CHK(q, 8'h00);
        run_cmd(OP_FLAG_RD, 12'h003, 8'h00);
        `CHK(r.data, 8'hff);
        $display("test handover done");
        fork
            run_cmd(OP_FLAG_CLAIM, 12'h003, 8'h00);
            begin
                repeat (300) @(posedge clk_in);
                #1 b_acc(1'b1, 1'b1, 12'h003, 8'h01);
            end
        join
        `CHK({7'h00, r.granted}, 8'h01);
        `CHK(r.data, 8'h00);
        $display("test polling done");
        fork
            run_cmd(OP_FLAG_CLAIM, 12'h005, 8'h00);
            b_acc(1'b1, 1'b1, 12'h005, 8'h00);
        join
        b_acc(1'b1, 1'b0, 12'h005, 8'h00);
        `CHK({7'h00, r.granted ^ (q == 8'h00)}, 8'h01);
        b_acc(1'b1, 1'b1, 12'h005, 8'h01);
        run_cmd(OP_FLAG_RELEASE, 12'h005, 8'h00);
        b_acc(1'b1, 1'b0, 12'h005, 8'h00);
        `CHK(q, 8'hff);
        $display("test contention done");
        cmd_in = '{OP_MEM_RD, 12'h0a5, 8'h00};
        cmd_valid_in = 1'b1;
        repeat (5) @(posedge clk_in);
        #1 nrst_in = 1'b0;
        cmd_valid_in = 1'b0;
        repeat (12) @(posedge clk_in);
        q = {init_busy_out, cmd_ready_out, resp_valid_out, port_data_oe_out, pins_out[15:12]};
        `CHK(q, 8'h8f);
        #1 nrst_in = 1'b1;
        run_cmd(OP_MEM_RD, 12'h0a5, 8'h00);
        `CHK(r.data, 8'h3c);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule
`default_nettype wire
